// File: rtl/iotp_defs.vh
`ifndef IOTP_DEFS_VH
`define IOTP_DEFS_VH

// ---------------------------------------------------------------
// register offsets (byte addresses, word aligned)
// ---------------------------------------------------------------
`define IOTP_OFS_CTRL 8'h00
`define IOTP_OFS_MATCH 8'h04
`define IOTP_OFS_FLUSH 8'h08
`define IOTP_OFS_STATUS 8'h0c
`define IOTP_OFS_MASTER 8'h40
`define IOTP_OFS_GROUP 8'h80

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define IOTP_CTRL_EN 0
`define IOTP_CTRL_GSE 1
`define IOTP_CTRL_SIV 2
`define IOTP_CTRL_ITR_LO 4
`define IOTP_CTRL_ITR_HI 7
`define IOTP_CTRL_PGSZ_LO 8
`define IOTP_CTRL_PGSZ_HI 10
`define IOTP_ITR_MAX 4'h8

// ---------------------------------------------------------------
// flush register and group control fields
// ---------------------------------------------------------------
`define IOTP_FLUSH_ALL 0
`define IOTP_FLUSH_GRP 1
`define IOTP_FLUSH_GID_LO 4
`define IOTP_FLUSH_GID_HI 6
`define IOTP_GRP_ACTIVE 0
`define IOTP_GRP_PASS 1
`define IOTP_GRP_BASE_LO 4

// ---------------------------------------------------------------
// translation entry layout
// ---------------------------------------------------------------
`define IOTP_PTE_VALID 1
`define IOTP_PTE_WRITE 2
`define IOTP_PTE_PPN_LO 8
`define IOTP_PTE_PPN_HI 27
`define IOTP_PAGE_SHIFT 5'd12
`define IOTP_WIN_SHIFT 5'd24

// ---------------------------------------------------------------
// cache geometry
// ---------------------------------------------------------------
`define IOTP_SETS 32
`define IOTP_SET_W 5
`define IOTP_LINE_W 18
`define IOTP_TAG_W 22
`define IOTP_GID_W 3
`define IOTP_MID_W 4

`endif

// File: rtl/iotp_unit.v
`include "iotp_defs.vh"

module iotp_unit (
    input wire sys_clk, // bus clock, 20 MHz
    input wire resetn, // synchronous reset, active low
    input wire [7:0] regAddr, // register byte address
    input wire [31:0] regWrData, // register write data
    input wire regWr, // register write strobe
    input wire regRd, // register read strobe
    output reg [31:0] regRdData_r, // read data, cycle after strobe
    input wire reqValid, // master request held until acknowledged
    input wire [31:0] incomingBusAddr, // master address
    input wire reqWrite, // 1 for posted write
    input wire reqBurst, // burst access
    input wire [3:0] reqMaster, // requesting master number
    output reg reqAck_r, // request finished, one cycle
    output reg reqErr_r, // error response for blocked read
    output reg reqDrop_r, // blocked write discarded
    output reg fwdValid_r, // forwarded access, one cycle
    output reg [31:0] fwdAddr_r, // outgoing address
    output reg fwdWrite_r, // outgoing direction
    output reg fwdBurst_r, // outgoing burst
    output reg fwdPrefetch_r, // prefetch requested
    output reg memReq_r, // table read request, held until ack
    output reg [31:0] memAddr_r, // table line address, 16-byte aligned
    input wire memAck, // table read done, one cycle
    input wire [127:0] memData, // table line, first entry in 127:96
    input wire memErr, // table read failed, with memAck
    output reg flushBusy_r // flush in progress
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_LOOK = 3'h1;
    localparam ST_FETCH = 3'h2;
    localparam ST_DONE = 3'h3;
    localparam ST_FLUSH = 3'h4;

    // low in-page mask for a page size code
    function [31:0] pageMask;
        input [2:0] pgsz;
        begin
            pageMask = ~(32'hffffffff << (`IOTP_PAGE_SHIFT + {2'h0, pgsz}));
        end
    endfunction

    // pick one of four entries, lowest address in the top lane
    function [31:0] pickEntry;
        input [127:0] line;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: pickEntry = line[127:96];
                2'h1: pickEntry = line[95:64];
                2'h2: pickEntry = line[63:32];
                default: pickEntry = line[31:0];
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // registers and storage
    // ---------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg [31:0] matchVal_r;
    reg [2:0] masterGrp_r [0:15];
    reg [31:0] grpCtrl_r [0:7];
    reg [`IOTP_TAG_W-1:0] tagMem_r [0:`IOTP_SETS-1];
    reg [127:0] dataMem_r [0:`IOTP_SETS-1];
    reg [2:0] state_r;
    reg flushPend_r;
    reg flushAll_r;
    reg [2:0] flushGrp_r;
    reg [4:0] flushIdx_r;
    reg [31:0] curAddr_r;
    reg curWrite_r;
    reg curBurst_r;
    reg [2:0] curGrp_r;
    reg [`IOTP_LINE_W-1:0] curLine_r;
    reg [1:0] curSel_r;
    reg [4:0] curSet_r;
    integer i;

    wire ctrlEn = ctrl_r[`IOTP_CTRL_EN];
    wire ctrlGse = ctrl_r[`IOTP_CTRL_GSE];
    wire ctrlSiv = ctrl_r[`IOTP_CTRL_SIV];
    wire [3:0] ctrlItr = ctrl_r[`IOTP_CTRL_ITR_HI:`IOTP_CTRL_ITR_LO];
    wire [2:0] ctrlPgsz = ctrl_r[`IOTP_CTRL_PGSZ_HI:`IOTP_CTRL_PGSZ_LO];

    // ---------------------------------------------------------------
    // request decode, from the raw request ports
    // ---------------------------------------------------------------
    // group from the master's assignment first, then its settings
    wire [2:0] reqGrp = masterGrp_r[reqMaster];
    wire [31:0] reqGrpCtrl = grpCtrl_r[reqGrp];
    // checked path only for active, non-pass-through groups when on
    wire reqChecked = ctrlEn & reqGrpCtrl[`IOTP_GRP_ACTIVE] & ~reqGrpCtrl[`IOTP_GRP_PASS];
    // exponents above eight are treated as eight: whole space
    wire itrFull = (ctrlItr >= `IOTP_ITR_MAX);
    wire [4:0] winShift = `IOTP_WIN_SHIFT + {1'b0, ctrlItr};
    wire [31:0] topMask = itrFull ? 32'h00000000 : (32'hffffffff << winShift);
    // top address bits must equal the match value
    wire inWindow = (((incomingBusAddr ^ matchVal_r) & topMask) == 32'h00000000);
    // table index: window bits down to 12 plus page code
    wire [31:0] idxFull = (incomingBusAddr & ~topMask) >> (`IOTP_PAGE_SHIFT + {2'h0, ctrlPgsz});
    wire [`IOTP_LINE_W-1:0] reqLine = idxFull[`IOTP_LINE_W+1:2];
    // set index: plain line bits, or group-spread when enabled
    wire [4:0] reqSet = ctrlGse ? {reqLine[1:0], reqGrp} : reqLine[4:0];

    // ---------------------------------------------------------------
    // lookup and entry check
    // ---------------------------------------------------------------
    wire [`IOTP_TAG_W-1:0] curTag = {curGrp_r, curLine_r, 1'b1};
    // hit needs valid bit 0 and the stored group and line
    wire tagHit = (tagMem_r[curSet_r] == curTag);
    // each line carries four consecutive entries
    wire [127:0] lineData = (state_r == ST_FETCH) ? memData : dataMem_r[curSet_r];
    wire [31:0] entry = pickEntry(lineData, curSel_r);
    // translation_entry fields: valid bit and write permission
    wire entryOk = entry[`IOTP_PTE_VALID] & (entry[`IOTP_PTE_WRITE] | ~curWrite_r);
    wire [31:0] lowMask = pageMask(ctrlPgsz);
    // phys_page_number bits 31:28 never reach the bus
    wire [31:0] physAddr = ({entry[`IOTP_PTE_PPN_HI:`IOTP_PTE_PPN_LO], 12'h000} & ~lowMask)
        | (curAddr_r & lowMask);
    wire [31:0] tableBase = {grpCtrl_r[curGrp_r][31:`IOTP_GRP_BASE_LO], 4'h0};
    // invalid entries are kept only when store-invalid is set
    wire fillOk = ~memErr & (entry[`IOTP_PTE_VALID] | ctrlSiv);
    wire flushHit = flushAll_r | (tagMem_r[flushIdx_r][21:19] == flushGrp_r);

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    // reads answer one cycle later; unmapped words read as zero
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            regRdData_r <= 32'h00000000;
        end
        else if (regRd)
        begin
            if (regAddr == `IOTP_OFS_CTRL)
                regRdData_r <= ctrl_r;
            else if (regAddr == `IOTP_OFS_MATCH)
                regRdData_r <= matchVal_r;
            else if (regAddr == `IOTP_OFS_FLUSH)
                regRdData_r <= {31'h00000000, flushBusy_r};
            else if (regAddr == `IOTP_OFS_STATUS)
                regRdData_r <= {28'h0000000, flushPend_r, state_r};
            else if (regAddr[7:6] == 2'h1 && regAddr[1:0] == 2'h0)
                regRdData_r <= {29'h00000000, masterGrp_r[regAddr[5:2]]};
            else if (regAddr[7:5] == 3'h4 && regAddr[1:0] == 2'h0)
                regRdData_r <= grpCtrl_r[regAddr[4:2]];
            else
                regRdData_r <= 32'h00000000;
        end
        else
        begin
            regRdData_r <= 32'h00000000;
        end
    end

    // configuration writes; unused bits are held at zero
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ctrl_r <= 32'h00000000;
            matchVal_r <= 32'h00000000;
            for (i = 0; i < 16; i = i + 1)
                masterGrp_r[i] <= 3'h0;
            for (i = 0; i < 8; i = i + 1)
                grpCtrl_r[i] <= 32'h00000000;
        end
        else if (regWr)
        begin
            if (regAddr == `IOTP_OFS_CTRL)
                ctrl_r <= regWrData & 32'h000007f7;
            else if (regAddr == `IOTP_OFS_MATCH)
                matchVal_r <= regWrData & 32'hff000000;
            else if (regAddr[7:6] == 2'h1 && regAddr[1:0] == 2'h0)
                masterGrp_r[regAddr[5:2]] <= regWrData[2:0];
            else if (regAddr[7:5] == 3'h4 && regAddr[1:0] == 2'h0)
                grpCtrl_r[regAddr[4:2]] <= regWrData & 32'hfffffff3;
        end
    end

    // ---------------------------------------------------------------
    // flush request capture
    // ---------------------------------------------------------------
    // a flush written while one runs is kept pending, but a new group number retargets a running group walk;
    // a group flush without group-set addressing only clears that
    // group's tags where they happen to sit
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            flushPend_r <= 1'b0;
            flushAll_r <= 1'b0;
            flushGrp_r <= 3'h0;
        end
        else if (regWr && regAddr == `IOTP_OFS_FLUSH
            && (regWrData[`IOTP_FLUSH_ALL] || regWrData[`IOTP_FLUSH_GRP]))
        begin
            flushPend_r <= 1'b1;
            flushAll_r <= regWrData[`IOTP_FLUSH_ALL] | ((flushPend_r | flushBusy_r) & flushAll_r);
            flushGrp_r <= regWrData[`IOTP_FLUSH_GID_HI:`IOTP_FLUSH_GID_LO];
        end
        else if (state_r == ST_IDLE && flushPend_r)
        begin
            flushPend_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // access engine
    // ---------------------------------------------------------------
    // one request at a time; flush takes priority in idle so that no
    // transfer slips past stale cache contents
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
            reqAck_r <= 1'b0;
            reqErr_r <= 1'b0;
            reqDrop_r <= 1'b0;
            fwdValid_r <= 1'b0;
            fwdAddr_r <= 32'h00000000;
            fwdWrite_r <= 1'b0;
            fwdBurst_r <= 1'b0;
            fwdPrefetch_r <= 1'b0;
            memReq_r <= 1'b0;
            memAddr_r <= 32'h00000000;
            flushBusy_r <= 1'b0;
            flushIdx_r <= 5'h00;
            curAddr_r <= 32'h00000000;
            curWrite_r <= 1'b0;
            curBurst_r <= 1'b0;
            curGrp_r <= 3'h0;
            curLine_r <= {`IOTP_LINE_W{1'b0}};
            curSel_r <= 2'h0;
            curSet_r <= 5'h00;
            for (i = 0; i < `IOTP_SETS; i = i + 1)
            begin
                tagMem_r[i] <= {`IOTP_TAG_W{1'b0}};
                dataMem_r[i] <= 128'h0;
            end
        end
        else
        begin
            reqAck_r <= 1'b0;
            reqErr_r <= 1'b0;
            reqDrop_r <= 1'b0;
            fwdValid_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (flushPend_r)
                    begin
                        state_r <= ST_FLUSH;
                        flushBusy_r <= 1'b1;
                        flushIdx_r <= 5'h00;
                    end
                    else if (reqValid)
                    begin
                        curAddr_r <= incomingBusAddr;
                        curWrite_r <= reqWrite;
                        curBurst_r <= reqBurst;
                        curGrp_r <= reqGrp;
                        curLine_r <= reqLine;
                        curSel_r <= idxFull[1:0];
                        curSet_r <= reqSet;
                        if (!reqChecked)
                        begin
                            // unchecked: forward untranslated, no attribute guess
                            state_r <= ST_DONE;
                            reqAck_r <= 1'b1;
                            fwdValid_r <= 1'b1;
                            fwdAddr_r <= incomingBusAddr;
                            fwdWrite_r <= reqWrite;
                            fwdBurst_r <= reqBurst;
                            fwdPrefetch_r <= 1'b0;
                        end
                        else if (!inWindow)
                        begin
                            // outside window: read errors, write vanishes
                            state_r <= ST_DONE;
                            reqAck_r <= 1'b1;
                            reqErr_r <= ~reqWrite;
                            reqDrop_r <= reqWrite;
                        end
                        else
                        begin
                            state_r <= ST_LOOK; // tag read costs the one cycle
                        end
                    end
                end
                ST_LOOK:
                begin
                    if (tagHit)
                    begin
                        state_r <= ST_DONE;
                        reqAck_r <= 1'b1;
                        fwdValid_r <= entryOk;
                        fwdAddr_r <= physAddr;
                        fwdWrite_r <= curWrite_r;
                        fwdBurst_r <= curBurst_r;
                        fwdPrefetch_r <= curBurst_r;
                        reqErr_r <= ~entryOk & ~curWrite_r;
                        reqDrop_r <= ~entryOk & curWrite_r;
                    end
                    else
                    begin
                        // miss: read the line from the group's table
                        state_r <= ST_FETCH;
                        memReq_r <= 1'b1;
                        memAddr_r <= tableBase + {10'h000, curLine_r, 4'h0};
                    end
                end
                ST_FETCH:
                begin
                    if (memAck)
                    begin
                        memReq_r <= 1'b0;
                        state_r <= ST_DONE;
                        reqAck_r <= 1'b1;
                        if (fillOk)
                        begin
                            tagMem_r[curSet_r] <= curTag;
                            dataMem_r[curSet_r] <= memData;
                        end
                        // a failed table read blocks the access like a bad entry
                        fwdValid_r <= entryOk & ~memErr;
                        fwdAddr_r <= physAddr;
                        fwdWrite_r <= curWrite_r;
                        fwdBurst_r <= curBurst_r;
                        fwdPrefetch_r <= curBurst_r;
                        reqErr_r <= ~(entryOk & ~memErr) & ~curWrite_r;
                        reqDrop_r <= ~(entryOk & ~memErr) & curWrite_r;
                    end
                end
                ST_DONE:
                begin
                    // gives the master one edge to drop its request
                    state_r <= ST_IDLE;
                end
                ST_FLUSH:
                begin
                    // one set per clock across all 32 sets
                    if (flushHit)
                        tagMem_r[flushIdx_r] <= tagMem_r[flushIdx_r] & {{(`IOTP_TAG_W-1){1'b1}}, 1'b0};
                    if (flushIdx_r == 5'h1f)
                    begin
                        state_r <= ST_IDLE;
                        flushBusy_r <= 1'b0;
                    end
                    flushIdx_r <= flushIdx_r + 5'h01;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // iotp_unit

// File: bench/iotp_unit_assertions.sv
module iotp_unit_checker (
    input wire sys_clk, // bus clock
    input wire resetn, // sync reset, active low
    input wire reqWrite, // access direction
    input wire reqAck_r, // request finished
    input wire reqErr_r, // error response
    input wire reqDrop_r, // write discarded
    input wire fwdValid_r, // access forwarded
    input wire fwdBurst_r, // forwarded burst
    input wire fwdPrefetch_r, // prefetch flag
    input wire memReq_r, // table read request
    input wire [31:0] memAddr_r, // table line address
    input wire memAck, // table read done
    input wire flushBusy_r // flush walk running
);
    // ---------------------------------------------------------------
    // flush length counter
    // ---------------------------------------------------------------
    logic [5:0] busyCnt_r;
    // counts busy cycles so the walk length can be checked past the repetition limit
    always @(posedge sys_clk)
    begin
        if (!resetn)
            busyCnt_r <= 6'h0;
        else if (flushBusy_r)
            busyCnt_r <= busyCnt_r + 6'h1;
        else
            busyCnt_r <= 6'h0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_err_read_only: assert property (reqErr_r |-> reqAck_r && !reqWrite && !fwdValid_r)
        else $error("error response on a write or without ack");
    a_drop_write_only: assert property (reqDrop_r |-> reqAck_r && reqWrite && !reqErr_r)
        else $error("drop on a read or without ack");
    a_fwd_clean: assert property (fwdValid_r |-> reqAck_r && !reqErr_r && !reqDrop_r)
        else $error("forward mixed with a block");
    a_flush_stall: assert property (flushBusy_r |-> !reqAck_r && !memReq_r)
        else $error("traffic during flush");
    a_flush_walk: assert property ($fell(flushBusy_r) |-> busyCnt_r == 6'h20)
        else $error("flush walk not 32 cycles");
    a_mem_hold: assert property (memReq_r && !memAck |=> memReq_r && $stable(memAddr_r))
        else $error("table request not held");
    a_line_align: assert property (memReq_r |-> memAddr_r[3:0] == 4'h0)
        else $error("table address not line aligned");
    a_prefetch_burst: assert property (fwdValid_r && fwdPrefetch_r |-> fwdBurst_r)
        else $error("prefetch on a single access");
    a_miss_ack: assert property (memReq_r && memAck |=> reqAck_r && !memReq_r)
        else $error("ack not in cycle after table data");
    c_err: cover property (reqErr_r);
    c_drop: cover property (reqDrop_r);
    c_flush: cover property ($fell(flushBusy_r));
    c_fill: cover property (memReq_r && memAck);
endmodule // iotp_unit_checker

bind iotp_unit iotp_unit_checker chk_i (.sys_clk, .resetn, .reqWrite, .reqAck_r, .reqErr_r,
    .reqDrop_r, .fwdValid_r, .fwdBurst_r, .fwdPrefetch_r, .memReq_r, .memAddr_r, .memAck,
    .flushBusy_r);

// File: bench/iotp_mem_model.sv
module iotp_mem_model (
    input wire sys_clk, // bus clock
    input wire resetn, // sync reset, active low
    input wire memReq, // line read request
    input wire [31:0] memAddr, // line address
    output logic memAck, // one-cycle answer
    output logic [127:0] memData, // four entries, first at top
    output wire memErr // read failure for tables placed at 0x003xxxxx
);
    logic [2:0] wait_r;
    logic slow_r;
    // a table read from the 0x003xxxxx area fails, to exercise the blocked miss
    assign memErr = memAck && (memAddr[31:20] == 12'h003);
    // entry flags by slot: writable, read-only, invalid, writable; top nibble set to be ignored
    function automatic logic [31:0] ent(input logic [31:0] a, input logic [1:0] k);
        logic [31:0] w;
        w = a + {28'h0, k, 2'h0};
        case (k)
            2'h0: ent = {8'hf0, w[15:0], 8'h06};
            2'h1: ent = {8'hf0, w[15:0], 8'h02};
            2'h2: ent = {8'hf0, w[15:0], 8'h00};
            default: ent = {8'hf0, w[15:0], 8'h86};
        endcase
    endfunction
    // ---------------------------------------------------------------
    // answer alternately fast and slow; idle data toggles so stale values never match
    // ---------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        memAck <= 1'b0;
        memData <= ~memData;
        if (!resetn)
        begin
            wait_r <= 3'h0;
            slow_r <= 1'b0;
            memData <= 128'h0;
        end
        else if (memReq && !memAck)
        begin
            wait_r <= wait_r + 3'h1;
            if (wait_r == (slow_r ? 3'h5 : 3'h0))
            begin
                memAck <= 1'b1;
                wait_r <= 3'h0;
                slow_r <= ~slow_r;
                memData <= {ent(memAddr, 2'h0), ent(memAddr, 2'h1), ent(memAddr, 2'h2),
                    ent(memAddr, 2'h3)};
            end
        end
    end
endmodule // iotp_mem_model

// File: bench/iotp_unit_test.sv
module iotp_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic reqValid = 1'b0;
    logic [31:0] incomingBusAddr = 32'h0;
    logic reqWrite = 1'b0;
    logic reqBurst = 1'b0;
    logic [3:0] reqMaster = 4'h0;
    wire [31:0] regRdData_r, fwdAddr_r, memAddr_r;
    wire [127:0] memData;
    wire reqAck_r, reqErr_r, reqDrop_r, fwdValid_r, fwdWrite_r, fwdBurst_r, fwdPrefetch_r;
    wire memReq_r, memAck, memErr, flushBusy_r;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int lat;
    logic sawMem;
    logic [31:0] lineAddr;
    iotp_unit uut (.sys_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_r,
        .reqValid, .incomingBusAddr, .reqWrite, .reqBurst, .reqMaster, .reqAck_r, .reqErr_r,
        .reqDrop_r, .fwdValid_r, .fwdAddr_r, .fwdWrite_r, .fwdBurst_r, .fwdPrefetch_r,
        .memReq_r, .memAddr_r, .memAck, .memData, .memErr, .flushBusy_r);
    iotp_mem_model mem (.sys_clk, .resetn, .memReq(memReq_r), .memAddr(memAddr_r), .memAck,
        .memData, .memErr);
    always #25 sys_clk = ~sys_clk;
    // hang guard: the whole run needs well under a tenth of this
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk(regRdData_r, e);
    endtask
    // one access; r is {err, drop, fwd, prefetch}, l the ack latency counting the request
    // cycle (0 skips it)
    task automatic xfer(input logic [3:0] m, input logic [31:0] a, input logic w,
        input logic b, input logic [3:0] r, input int l, input logic [31:0] f);
        @(posedge sys_clk);
        reqMaster <= m;
        incomingBusAddr <= a;
        reqWrite <= w;
        reqBurst <= b;
        reqValid <= 1'b1;
        lat = 1;
        sawMem = 1'b0;
        while (reqAck_r !== 1'b1 && lat < 200)
        begin
            @(posedge sys_clk);
            #1 lat++;
            if (memReq_r === 1'b1)
            begin
                sawMem = 1'b1;
                lineAddr = memAddr_r;
            end
        end
        chk({28'h0, reqErr_r, reqDrop_r, fwdValid_r, fwdPrefetch_r}, {28'h0, r});
        if (l > 0)
            chk(32'(lat), 32'(l));
        if (r[1])
            chk(fwdAddr_r, f);
        @(posedge sys_clk);
        reqValid <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'hffffffff);
        rd(8'h00, 32'h000007f7);
        rd(8'h20, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h4c, 32'h1);
        wr(8'h54, 32'h2);
        wr(8'h84, 32'h00100001);
        wr(8'h88, 32'h00200003);
        wr(8'h04, 32'h05000000);
        xfer(4'h3, 32'h05003abc, 1'b0, 1'b1, 4'h2, 2, 32'h05003abc);
        $display("test registers done");
        wr(8'h00, 32'h1);
        xfer(4'h3, 32'h06003abc, 1'b0, 1'b0, 4'h8, 2, 32'h0);
        xfer(4'h3, 32'h06003abc, 1'b1, 1'b0, 4'h4, 2, 32'h0);
        xfer(4'h5, 32'h12345678, 1'b1, 1'b1, 4'h2, 2, 32'h12345678);
        $display("test window done");
        xfer(4'h3, 32'h05003abc, 1'b0, 1'b1, 4'h3, 0, 32'h0000cabc);
        chk(32'(lat > 4), 32'h1);
        chk(lineAddr, 32'h00100000);
        xfer(4'h3, 32'h05001123, 1'b0, 1'b0, 4'h2, 3, 32'h00004123);
        chk({31'h0, sawMem}, 32'h0);
        xfer(4'h3, 32'h05001123, 1'b1, 1'b0, 4'h4, 3, 32'h0);
        xfer(4'h3, 32'h05002000, 1'b0, 1'b0, 4'h8, 3, 32'h0);
        xfer(4'h3, 32'h05000010, 1'b1, 1'b0, 4'h2, 3, 32'h00000010);
        wr(8'h00, 32'h11);
        xfer(4'h3, 32'h04003abc, 1'b0, 1'b0, 4'h2, 3, 32'h0000cabc);
        xfer(4'h3, 32'h05003abc, 1'b0, 1'b0, 4'h2, 0, 32'h0400cabc);
        chk(lineAddr, 32'h00104000);
        $display("test translate done");
        wr(8'h08, 32'h1);
        xfer(4'h3, 32'h05003abc, 1'b0, 1'b0, 4'h2, 0, 32'h0400cabc);
        chk(32'(lat > 32), 32'h1);
        chk({31'h0, sawMem}, 32'h1);
        $display("test flush done");
        wr(8'h88, 32'h00200001);
        wr(8'h00, 32'h13);
        wr(8'h08, 32'h1);
        repeat (40) @(posedge sys_clk);
        xfer(4'h3, 32'h04003abc, 1'b0, 1'b0, 4'h2, 0, 32'h0000cabc);
        xfer(4'h5, 32'h04003abc, 1'b0, 1'b0, 4'h2, 0, 32'h0000cabc);
        chk(lineAddr, 32'h00200000);
        xfer(4'h3, 32'h04003abc, 1'b0, 1'b0, 4'h2, 3, 32'h0000cabc);
        chk({31'h0, sawMem}, 32'h0);
        wr(8'h08, 32'h12);
        repeat (40) @(posedge sys_clk);
        xfer(4'h5, 32'h04003abc, 1'b0, 1'b0, 4'h2, 3, 32'h0000cabc);
        xfer(4'h3, 32'h04003abc, 1'b0, 1'b0, 4'h2, 0, 32'h0000cabc);
        chk({31'h0, sawMem}, 32'h1);
        $display("test group set done");
        xfer(4'h3, 32'h04006000, 1'b0, 1'b0, 4'h8, 0, 32'h0);
        xfer(4'h3, 32'h04006000, 1'b0, 1'b0, 4'h8, 0, 32'h0);
        chk({31'h0, sawMem}, 32'h1);
        wr(8'h00, 32'h17);
        xfer(4'h3, 32'h04006000, 1'b0, 1'b0, 4'h8, 0, 32'h0);
        xfer(4'h3, 32'h04006000, 1'b0, 1'b0, 4'h8, 3, 32'h0);
        chk({31'h0, sawMem}, 32'h0);
        wr(8'h80, 32'h00300001);
        xfer(4'h0, 32'h04003abc, 1'b0, 1'b0, 4'h8, 0, 32'h0);
        xfer(4'h0, 32'h04003abc, 1'b0, 1'b0, 4'h8, 0, 32'h0);
        chk({31'h0, sawMem}, 32'h1);
        $display("test store invalid done");
        finish_test();
    end
endmodule // iotp_unit_test
